// [logic/sam_address_map.sv]
// What this block does
// - reserved address reads and writes end in a bus fault response
// - one fixed 4 GB map; every address resolves to exactly one region
// - SRAM alias window from 0x2200_0000 maps to SRAM bit-band bits
// - 0x4200_0000..0x43FF_FFFF decode as the peripheral alias window
// - 0xE000_E000 4 KB slot selects core system registers
// - trace, watchpoint, breakpoint and trace-port slots are decoded
// - Normal regions may reorder and read speculatively
// - Device writes may be buffered but keep Device/Strongly-Ordered order
// - Strongly Ordered traffic is never buffered and keeps total order
// - execute-never fetches blocked; fault only when the instruction executes
// - two Device/Strongly-Ordered accesses are observed in program order
// - code region is Normal, executable
// - SRAM region is Normal, executable, holds bit-band and alias
// - peripheral region is Device, execute-never
// - external device region is Device, execute-never
// - private bus region is Strongly Ordered, execute-never
// - fetches ahead and to branch targets must be tolerated
// - data memory barrier holds later transactions until all complete
// - data sync barrier stalls later instructions until all complete
// - instruction sync barrier forces a refetch of later instructions
// - enabled protection unit may replace type and execute-never
// - exception priority change effective by end of a following data sync barrier
// - alias data writes are read-modify-write; alias fetches not remapped
module sam_address_map
  import sam_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // request from core
  input wire logic reqValid,
  input wire logic [31:0] reqAddr,
  input wire logic reqWrite,
  input wire logic reqFetch,
  output logic reqReady,
  // downstream issue and completion
  output logic issValid,
  output logic [31:0] issAddr,
  output logic issWrite,
  output logic [4:0] issSel,
  output logic [1:0] issType,
  output logic issBuffered,
  output logic issRmw,
  input wire logic cplValid,
  // response to core
  output logic rspFault,
  output logic rspValid,
  output logic fetchExecNever,
  // execution of a fetched instruction
  input wire logic execValid,
  input wire logic execFromNever,
  output logic execFault,
  // barriers
  input wire logic dmbReq,
  input wire logic dsbReq,
  input wire logic isbReq,
  output logic execStall,
  output logic fetchFlush,
  output logic prioCommit,
  input wire logic prioChange,
  // protection unit override
  input wire logic protEnable,
  input wire logic protHit,
  input wire logic [1:0] protType,
  input wire logic protExecNever
);
  import sam_pkg::*;

  typedef enum {SAM_IDLE, SAM_DMB_WAIT, SAM_DSB_WAIT} sam_bar_t;
  sam_bar_t barState_r;
  sam_attr_if att ();
  sam_mtype_t effType;
  logic effExecNever;
  logic [3:0] outstCnt;
  logic anyOutst;
  logic accept;
  logic isOrdered;
  logic orderBlock;
  logic barBlock;
  logic prioPend_r;
  logic cplStrong;
  logic strongOpen_r;
  logic orderedOutst_r;
  logic readyCond;
  logic drainNxt;

  assign att.addr = reqAddr;
  assign att.isFetch = reqFetch;

  sam_region_dec u_dec (
    .att(att)
  );

  // protection unit wins over the default map attributes
  always_comb begin
    effType = att.mtype;
    effExecNever = att.execNever;
    if (protEnable && protHit) begin
      effType = sam_mtype_t'(protType);
      effExecNever = protExecNever;
    end
  end

  assign isOrdered = (effType != SAM_NORMAL);
  // ordered traffic waits behind any open ordered or strongly ordered access
  assign orderBlock = (isOrdered && orderedOutst_r) || strongOpen_r
    || (effType == SAM_STRONG && outstCnt != 4'h0);
  assign barBlock = (barState_r != SAM_IDLE) || dmbReq || dsbReq;
  // normal traffic is held back only by an open strongly ordered access or a full outstanding count
  assign readyCond = !orderBlock && (outstCnt != OUTST_MAX);
  // ready rises only into a drained pipe, so any type may be taken next;
  // costs a round trip per access but keeps ready equal to taken
  assign drainNxt = (outstCnt == 4'h0) || (outstCnt == 4'h1 && cplValid);
  assign accept = reqValid && reqReady && readyCond && !barBlock;

  sam_order_ctl u_ord (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .issue(accept && !att.reserved && !(reqFetch && effExecNever)),
    .done(cplValid),
    .strongOrder(strongOpen_r),
    .outst(outstCnt),
    .anyOutst(anyOutst)
  );

  assign cplStrong = cplValid && outstCnt == 4'h1;

  // ordered-class occupancy: cleared once every access has drained
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      orderedOutst_r <= 1'b0;
      strongOpen_r <= 1'b0;
    end else if (accept && !att.reserved && isOrdered && !reqFetch) begin
      orderedOutst_r <= 1'b1;
      strongOpen_r <= (effType == SAM_STRONG);
    end else if (cplStrong) begin
      orderedOutst_r <= 1'b0;
      strongOpen_r <= 1'b0;
    end
  end

  // issue to downstream
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      issValid <= 1'b0;
      issAddr <= 32'h0000_0000;
      issWrite <= 1'b0;
      issSel <= 5'h00;
      issType <= 2'h0;
      issBuffered <= 1'b0;
      issRmw <= 1'b0;
    end else begin
      issValid <= accept && !att.reserved && !(reqFetch && effExecNever);
      issAddr <= reqAddr;
      issWrite <= reqWrite && !reqFetch;
      issSel <= att.sel;
      issType <= effType;
      // device writes may post; strongly ordered never does
      issBuffered <= reqWrite && effType == SAM_DEVICE;
      issRmw <= reqWrite && !reqFetch && (att.sel == SAM_SEL_SRAM_ALIAS
        || att.sel == SAM_SEL_PERIPH_ALIAS);
    end
  end

  // core-facing answer: fault for reserved space, flag for blocked fetches
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rspValid <= 1'b0;
      rspFault <= 1'b0;
      fetchExecNever <= 1'b0;
      reqReady <= 1'b0;
    end else begin
      rspValid <= accept && (att.reserved || (reqFetch && effExecNever));
      rspFault <= accept && att.reserved;
      // a prefetch into execute-never space only marks the word; no fault yet
      fetchExecNever <= accept && !att.reserved && reqFetch && effExecNever;
      reqReady <= readyCond && drainNxt && !barBlock && !accept;
    end
  end

  // fault only when the marked instruction reaches execution
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) execFault <= 1'b0;
    else execFault <= execValid && execFromNever;
  end

  // barrier sequencing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) barState_r <= SAM_IDLE;
    else begin
      case (barState_r)
        SAM_IDLE: begin
          if (dsbReq) barState_r <= SAM_DSB_WAIT;
          else if (dmbReq) barState_r <= SAM_DMB_WAIT;
        end
        SAM_DMB_WAIT: if (!anyOutst && outstCnt == 4'h0) barState_r <= SAM_IDLE;
        SAM_DSB_WAIT: if (outstCnt == 4'h0 && !strongOpen_r) barState_r <= SAM_IDLE;
        default: barState_r <= SAM_IDLE;
      endcase
    end
  end

  // a pending priority change commits when a following data sync barrier ends
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prioPend_r <= 1'b0;
      prioCommit <= 1'b0;
      execStall <= 1'b0;
      fetchFlush <= 1'b0;
    end else begin
      execStall <= dsbReq || (barState_r == SAM_DSB_WAIT
        && !(outstCnt == 4'h0 && !strongOpen_r));
      fetchFlush <= isbReq;
      if (barState_r == SAM_DSB_WAIT && outstCnt == 4'h0 && !strongOpen_r) begin
        prioCommit <= prioPend_r || prioChange;
        prioPend_r <= 1'b0;
      end else begin
        prioCommit <= 1'b0;
        if (prioChange) prioPend_r <= 1'b1;
      end
    end
  end
endmodule : sam_address_map

// [logic/sam_attr_if.sv]
interface sam_attr_if;
  import sam_pkg::*;
  logic [31:0] addr;
  logic isFetch;
  sam_sel_t sel;
  sam_mtype_t mtype;
  logic execNever;
  logic reserved;
  modport dec (input addr, input isFetch, output sel, output mtype, output execNever,
    output reserved);
  modport user (output addr, output isFetch, input sel, input mtype, input execNever,
    input reserved);
endinterface : sam_attr_if

// [logic/sam_order_ctl.sv]
module sam_order_ctl
  import sam_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // issue and completion
  input wire logic issue,
  input wire logic done,
  input wire logic strongOrder,
  // status
  output logic [3:0] outst,
  output logic anyOutst
);
  // counts accepted-but-unfinished transactions of every ordering class together
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) outst <= 4'h0;
    else outst <= outst + {3'h0, issue} - {3'h0, done && outst != 4'h0};
  end
  assign anyOutst = (outst != 4'h0) || strongOrder;
endmodule : sam_order_ctl

// [logic/sam_pkg.sv]
package sam_pkg;
  localparam int ADDR_W = 32;
  // region attribute encodings
  typedef enum logic [1:0] {SAM_NORMAL, SAM_DEVICE, SAM_STRONG} sam_mtype_t;
  typedef enum logic [4:0] {
    SAM_SEL_NONE, SAM_SEL_FLASH, SAM_SEL_SRAM, SAM_SEL_SRAM_ALIAS, SAM_SEL_PERIPH,
    SAM_SEL_PERIPH_ALIAS, SAM_SEL_EXT_RAM, SAM_SEL_EXT_DEV, SAM_SEL_ITRACE,
    SAM_SEL_WATCH, SAM_SEL_BREAK, SAM_SEL_CORE_SYS, SAM_SEL_TRACE_PORT
  } sam_sel_t;
  // memory map boundaries
  localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] FLASH_LAST = 32'h0000_3FFF;
  localparam logic [31:0] CODE_LAST = 32'h1FFF_FFFF;
  localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] SRAM_LAST = 32'h2000_0FFF;
  localparam logic [31:0] SRAM_BB_LAST = 32'h200F_FFFF;
  localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
  localparam logic [31:0] SRAM_ALIAS_LAST = 32'h2201_FFFF;
  localparam logic [31:0] SRAM_REG_LAST = 32'h3FFF_FFFF;
  localparam logic [31:0] PERI_BASE = 32'h4000_0000;
  localparam logic [31:0] PERI_BB_LAST = 32'h400F_FFFF;
  localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
  localparam logic [31:0] PERI_ALIAS_LAST = 32'h43FF_FFFF;
  localparam logic [31:0] PERI_REG_LAST = 32'h5FFF_FFFF;
  localparam logic [31:0] EXT_RAM_BASE = 32'h6000_0000;
  localparam logic [31:0] EXT_RAM_LAST = 32'h9FFF_FFFF;
  localparam logic [31:0] EXT_DEV_BASE = 32'hA000_0000;
  localparam logic [31:0] EXT_DEV_LAST = 32'hDFFF_FFFF;
  localparam logic [31:0] PRIV_BASE = 32'hE000_0000;
  localparam logic [31:0] PRIV_LAST = 32'hE00F_FFFF;
  localparam logic [31:0] ITRACE_BASE = 32'hE000_0000;
  localparam logic [31:0] WATCH_BASE = 32'hE000_1000;
  localparam logic [31:0] BREAK_BASE = 32'hE000_2000;
  localparam logic [31:0] CORE_SYS_BASE = 32'hE000_E000;
  localparam logic [31:0] TRACE_PORT_BASE = 32'hE004_0000;
  // 4 KB slot granularity
  localparam int SLOT_SHIFT = 12;
  localparam int PERI_SLOT_CNT = 256;
  // listed peripheral slots (index = offset >> 12 in first peripheral MB)
  localparam logic [255:0] PERI_SLOT_MAP = (256'h1 << 8'h00) | (256'h1 << 8'h04)
    | (256'h1 << 8'h05) | (256'h1 << 8'h06) | (256'h1 << 8'h07) | (256'h1 << 8'h08)
    | (256'h1 << 8'h0C) | (256'h1 << 8'h0D) | (256'h1 << 8'h20) | (256'h1 << 8'h24)
    | (256'h1 << 8'h30) | (256'h1 << 8'h31) | (256'h1 << 8'h32) | (256'h1 << 8'h3C)
    | (256'h1 << 8'hFD) | (256'h1 << 8'hFE);
  localparam int OUTST_W = 4;
  localparam logic [3:0] OUTST_MAX = 4'hF;
endpackage : sam_pkg

// [logic/sam_region_dec.sv]
module sam_region_dec
  import sam_pkg::*;
(
  sam_attr_if.dec att
);
  logic [31:0] a;
  logic [7:0] slot;
  assign a = att.addr;
  assign slot = a[19:12];
  always_comb begin
    att.sel = SAM_SEL_NONE;
    att.mtype = SAM_NORMAL;
    att.execNever = 1'b0;
    att.reserved = 1'b0;
    if (a <= CODE_LAST) begin
      att.sel = (a <= FLASH_LAST) ? SAM_SEL_FLASH : SAM_SEL_NONE;
    end else if (a <= SRAM_REG_LAST) begin
      if (a <= SRAM_LAST) att.sel = SAM_SEL_SRAM;
      else if (a >= SRAM_ALIAS_BASE && a <= SRAM_ALIAS_LAST) att.sel = SAM_SEL_SRAM_ALIAS;
    end else if (a <= PERI_REG_LAST) begin
      att.mtype = SAM_DEVICE;
      att.execNever = 1'b1;
      if (a <= PERI_BB_LAST && PERI_SLOT_MAP[slot]) att.sel = SAM_SEL_PERIPH;
      else if (a >= PERI_ALIAS_BASE && a <= PERI_ALIAS_LAST) att.sel = SAM_SEL_PERIPH_ALIAS;
    end else if (a <= EXT_RAM_LAST) begin
      att.sel = SAM_SEL_NONE;
    end else if (a <= EXT_DEV_LAST) begin
      att.mtype = SAM_DEVICE;
      att.execNever = 1'b1;
    end else begin
      att.mtype = SAM_STRONG;
      att.execNever = 1'b1;
      if (a[31:12] == ITRACE_BASE[31:12]) att.sel = SAM_SEL_ITRACE;
      else if (a[31:12] == WATCH_BASE[31:12]) att.sel = SAM_SEL_WATCH;
      else if (a[31:12] == BREAK_BASE[31:12]) att.sel = SAM_SEL_BREAK;
      else if (a[31:12] == CORE_SYS_BASE[31:12]) att.sel = SAM_SEL_CORE_SYS;
      else if (a[31:12] == TRACE_PORT_BASE[31:12]) att.sel = SAM_SEL_TRACE_PORT;
    end
    // alias fetches are not remapped: alias space is data only
    if (att.isFetch && (att.sel == SAM_SEL_SRAM_ALIAS || att.sel == SAM_SEL_PERIPH_ALIAS))
      att.sel = SAM_SEL_NONE;
    att.reserved = (att.sel == SAM_SEL_NONE);
  end
endmodule : sam_region_dec

// [tb/sam_address_map_monitor.sv]
module sam_address_map_monitor
  import sam_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // watched ports
  input wire logic reqValid,
  input wire logic [31:0] reqAddr,
  input wire logic reqWrite,
  input wire logic reqFetch,
  input wire logic reqReady,
  input wire logic issValid,
  input wire logic [31:0] issAddr,
  input wire logic [4:0] issSel,
  input wire logic [1:0] issType,
  input wire logic issBuffered,
  input wire logic issRmw,
  input wire logic rspFault,
  input wire logic rspValid,
  input wire logic fetchExecNever,
  input wire logic execValid,
  input wire logic execFromNever,
  input wire logic execFault,
  input wire logic dmbReq,
  input wire logic dsbReq,
  input wire logic isbReq,
  input wire logic fetchFlush,
  input wire logic protEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic acc;
  assign acc = reqValid && reqReady && !dmbReq && !dsbReq;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  chk_answer_next_cycle: assert property (
    acc |=> issValid || rspValid) else $error("request not answered next cycle");
  chk_reserved_faults: assert property (
    acc && reqAddr >= 32'h0000_4000 && reqAddr <= CODE_LAST |=> rspValid && rspFault)
    else $error("reserved access did not fault");
  chk_core_sys_sel: assert property (
    acc && !reqFetch && reqAddr[31:12] == 20'hE000E |=> issValid && issSel == SAM_SEL_CORE_SYS)
    else $error("core system slot not selected");
  chk_alias_write_rmw: assert property (
    acc && reqWrite && !reqFetch && reqAddr >= SRAM_ALIAS_BASE && reqAddr <= SRAM_ALIAS_LAST
    |=> issRmw && issSel == SAM_SEL_SRAM_ALIAS) else $error("alias write not remapped");
  chk_fetch_never_blocked: assert property (
    acc && reqFetch && !protEnable && reqAddr[31:12] == 20'hE000E
    |=> fetchExecNever && !issValid) else $error("fetch from execute-never issued");
  chk_exec_fault_late: assert property (
    execValid && execFromNever |=> execFault) else $error("no fault on execution");
  chk_isb_refetch: assert property (
    isbReq |=> fetchFlush) else $error("no refetch after sync barrier");
  chk_priv_strong_type: assert property (
    issValid && !$past(protEnable) && issAddr[31:20] == 12'hE00 |-> issType == 2'h2)
    else $error("private bus not strongly ordered");
  chk_periph_device_type: assert property (
    issValid && !$past(protEnable) && issAddr[31:29] == 3'b010 |-> issType == 2'h1)
    else $error("peripheral not device type");
  chk_strong_unbuffered: assert property (
    issValid && issType == 2'h2 |-> !issBuffered ##1 !issValid)
    else $error("strongly ordered access buffered or overtaken");
endmodule // sam_address_map_monitor

bind sam_address_map sam_address_map_monitor u_mon (
  .sys_clk(sys_clk), .arst_n(arst_n), .reqValid(reqValid), .reqAddr(reqAddr),
  .reqWrite(reqWrite), .reqFetch(reqFetch), .reqReady(reqReady), .issValid(issValid),
  .issAddr(issAddr), .issSel(issSel), .issType(issType), .issBuffered(issBuffered),
  .issRmw(issRmw), .rspFault(rspFault), .rspValid(rspValid),
  .fetchExecNever(fetchExecNever), .execValid(execValid), .execFromNever(execFromNever),
  .execFault(execFault), .dmbReq(dmbReq), .dsbReq(dsbReq), .isbReq(isbReq),
  .fetchFlush(fetchFlush), .protEnable(protEnable));

// [tb/sam_address_map_tb.sv]
module sam_address_map_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sam_pkg::*;
  logic sys_clk, arst_n, reqValid, reqWrite, reqFetch, reqReady, issValid, issWrite;
  logic [31:0] reqAddr, issAddr;
  logic [4:0] issSel;
  logic [1:0] issType, protType;
  logic issBuffered, issRmw, cplValid, rspFault, rspValid, fetchExecNever, execValid;
  logic execFromNever, execFault, dmbReq, dsbReq, isbReq, execStall, fetchFlush;
  logic prioCommit, prioChange, protEnable, protHit, protExecNever, slow;
  int errCount = 0;
  int checked = 0;
  int cyc = 0;
  sam_address_map uut (
    .sys_clk(sys_clk), .arst_n(arst_n), .reqValid(reqValid), .reqAddr(reqAddr),
    .reqWrite(reqWrite), .reqFetch(reqFetch), .reqReady(reqReady), .issValid(issValid),
    .issAddr(issAddr), .issWrite(issWrite), .issSel(issSel), .issType(issType),
    .issBuffered(issBuffered), .issRmw(issRmw), .cplValid(cplValid), .rspFault(rspFault),
    .rspValid(rspValid), .fetchExecNever(fetchExecNever), .execValid(execValid),
    .execFromNever(execFromNever), .execFault(execFault), .dmbReq(dmbReq), .dsbReq(dsbReq),
    .isbReq(isbReq), .execStall(execStall), .fetchFlush(fetchFlush),
    .prioCommit(prioCommit), .prioChange(prioChange), .protEnable(protEnable),
    .protHit(protHit), .protType(protType), .protExecNever(protExecNever));
  sam_cpl_model u_cpl (.sys_clk(sys_clk), .arst_n(arst_n), .issValid(issValid),
    .slow(slow), .cplValid(cplValid));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errCount++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // holds the request until reqReady seen high, then returns at the next negedge for the caller to sample the answer
  task automatic req(input logic [31:0] a, input logic w, input logic f);
    int n;
    n = 0;
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqAddr <= a;
    reqWrite <= w;
    reqFetch <= f;
    @(negedge sys_clk);
    while (reqReady !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    reqValid <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic m(input logic [31:0] a, input logic w, input sam_sel_t s, input sam_mtype_t t);
    req(a, w, 1'b0);
    chk("fault", rspFault, s == SAM_SEL_NONE);
    chk("answer", rspValid, s == SAM_SEL_NONE);
    chk("issue", issValid, s != SAM_SEL_NONE);
    if (s != SAM_SEL_NONE) begin
      chk("sel", issSel, s);
      chk("type", issType, t);
      chk("addr", issAddr, a);
      chk("write", issWrite, w);
      chk("posted", issBuffered, w && t == SAM_DEVICE);
      chk("rmw", issRmw, w && (s == SAM_SEL_SRAM_ALIAS || s == SAM_SEL_PERIPH_ALIAS));
    end
  endtask
  task automatic t_map();
    m(32'h0000_0100, 1'b0, SAM_SEL_FLASH, SAM_NORMAL);
    m(32'h0000_4000, 1'b0, SAM_SEL_NONE, SAM_NORMAL);
    m(32'h2000_0004, 1'b0, SAM_SEL_SRAM, SAM_NORMAL);
    m(32'h2000_1000, 1'b1, SAM_SEL_NONE, SAM_NORMAL);
    m(32'h2200_0000, 1'b1, SAM_SEL_SRAM_ALIAS, SAM_NORMAL);
    m(32'h4000_4000, 1'b0, SAM_SEL_PERIPH, SAM_DEVICE);
    m(32'h4000_C000, 1'b1, SAM_SEL_PERIPH, SAM_DEVICE);
    m(32'h4000_1000, 1'b0, SAM_SEL_NONE, SAM_NORMAL);
    m(32'h4200_0000, 1'b0, SAM_SEL_PERIPH_ALIAS, SAM_DEVICE);
    m(32'h4400_0000, 1'b0, SAM_SEL_NONE, SAM_NORMAL);
    m(32'hE000_0000, 1'b0, SAM_SEL_ITRACE, SAM_STRONG);
    m(32'hE000_1000, 1'b0, SAM_SEL_WATCH, SAM_STRONG);
    m(32'hE000_2000, 1'b0, SAM_SEL_BREAK, SAM_STRONG);
    m(32'hE000_E000, 1'b1, SAM_SEL_CORE_SYS, SAM_STRONG);
    m(32'hE004_0000, 1'b0, SAM_SEL_TRACE_PORT, SAM_STRONG);
    m(32'hE010_0000, 1'b0, SAM_SEL_NONE, SAM_NORMAL);
  endtask
  task automatic t_exec();
    req(32'hE000_E000, 1'b0, 1'b1);
    chk("xn", fetchExecNever, 1'b1);
    chk("xnfault", rspFault, 1'b0);
    @(posedge sys_clk);
    execValid <= 1'b1;
    execFromNever <= 1'b1;
    @(posedge sys_clk);
    execValid <= 1'b0;
    isbReq <= 1'b1;
    @(negedge sys_clk);
    chk("execFault", execFault, 1'b1);
    @(posedge sys_clk);
    isbReq <= 1'b0;
    @(negedge sys_clk);
    chk("flush", fetchFlush, 1'b1);
  endtask
  task automatic t_barrier();
    int n;
    n = 0;
    @(posedge sys_clk);
    slow <= 1'b1;
    req(32'hE000_E000, 1'b1, 1'b0);
    @(posedge sys_clk);
    dsbReq <= 1'b1;
    prioChange <= 1'b1;
    @(posedge sys_clk);
    dsbReq <= 1'b0;
    prioChange <= 1'b0;
    @(negedge sys_clk);
    chk("stall", execStall, 1'b1);
    while (prioCommit !== 1'b1 && n < 30) begin
      @(negedge sys_clk);
      n++;
    end
    chk("prio", prioCommit, 1'b1);
    repeat (2) @(negedge sys_clk);
    chk("stallEnd", execStall, 1'b0);
    @(posedge sys_clk);
    dmbReq <= 1'b1;
    @(posedge sys_clk);
    dmbReq <= 1'b0;
    @(negedge sys_clk);
    chk("dmbHold", reqReady, 1'b0);
    repeat (2) @(negedge sys_clk);
    chk("dmbFree", reqReady, 1'b1);
    @(posedge sys_clk);
    slow <= 1'b0;
  endtask
  task automatic t_prot();
    @(posedge sys_clk);
    protEnable <= 1'b1;
    protHit <= 1'b1;
    protType <= 2'h0;
    req(32'h4000_4000, 1'b0, 1'b0);
    chk("protType", issType, SAM_NORMAL);
    @(posedge sys_clk);
    protEnable <= 1'b0;
  endtask
  initial begin
    {arst_n, reqValid, reqWrite, reqFetch, execValid, execFromNever, dmbReq} = 7'h00;
    {dsbReq, isbReq, prioChange, protEnable, protHit, protExecNever, slow} = 7'h00;
    reqAddr = 32'h0;
    protType = 2'h0;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_map();
    t_exec();
    t_barrier();
    t_prot();
    test_done();
  end
endmodule // sam_address_map_tb

// [tb/sam_cpl_model.sv]
module sam_cpl_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // issue in, completion out
  input wire logic issValid,
  input wire logic slow,
  output logic cplValid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pipe_r;
  // change slow only while idle, or completions go missing or repeat
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) pipe_r <= 8'h00;
    else pipe_r <= {pipe_r[6:0], issValid};
  end
  assign cplValid = slow ? pipe_r[7] : pipe_r[0];
endmodule // sam_cpl_model
